// ==== auto_ack_retransmit_link.sv ====
// Packet link layer: auto acknowledgement, retransmission and legacy format
`default_nettype none
module auto_ack_retransmit_link #(
   parameter int UNIT_CYC = link_pkg::WAIT_UNIT_CYC
) (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   // Special-function register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Outgoing frame to the radio
   output logic air_tx_valid,
   output logic air_tx_is_ack,
   output logic [1:0] air_tx_pid,
   output logic [7:0] air_tx_data,
   output logic air_tx_has_pay,
   output logic air_tx_has_pcf,
   output logic air_tx_has_crc,
   input wire logic air_tx_done,
   // Incoming frame from the radio
   output logic radio_rx_on,
   input wire logic air_rx_valid,
   input wire logic air_rx_is_ack,
   input wire logic air_rx_has_pay,
   input wire logic air_rx_crc_ok,
   input wire logic [1:0] air_rx_pid,
   input wire logic [15:0] air_rx_crc,
   input wire logic [7:0] air_rx_data,
   // Master interface configuration
   output logic [6:0] spi_cfg0
);
   typedef struct packed {
      link_pkg::state_type st;
      logic rfce_d;
      logic blocked;
      logic txq_full;
      logic [7:0] txq_data;
      logic [1:0] packet_ident;
      logic [3:0] rcnt;
      logic rx_ready;
      logic tx_sent;
      logic retry_limit_flag;
      logic ackpay_out;
      logic [7:0] rx_data;
      logic tx_go;
      logic tx_ack;
      logic [1:0] tx_pid;
      logic [7:0] tx_data;
      logic tx_pay;
      logic tx_pcf;
      logic tx_crc;
      logic [6:0] spi_cfg0;
      logic [2:0] rctl;
      logic [5:0] aa_mask;
      logic [7:0] retry_cfg;
      logic [7:0] rdata;
   } link_state_type;

   link_state_type q, n;
   logic legacy, auto_ack, primary_receiver, rfce, rfce_rise;
   logic data_rx, ack_rx, is_dup, timeout, pop_ackpay;
   logic [3:0] limit;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
      hit = (a == reg_addr);
   endfunction

   assign limit = q.retry_cfg[link_pkg::RETRY_LIM_LSB +: 4];
   assign legacy = (q.aa_mask == 6'h00) && (limit == 4'h0);
   assign auto_ack = q.aa_mask[0] && !legacy;
   assign primary_receiver = q.rctl[link_pkg::RCTL_PRX_BIT];
   assign rfce = q.rctl[link_pkg::RCTL_CE_BIT];
   assign rfce_rise = rfce && !q.rfce_d;
   assign data_rx = air_rx_valid && air_rx_crc_ok && !air_rx_is_ack;
   assign ack_rx = air_rx_valid && air_rx_crc_ok && air_rx_is_ack;
   assign pop_ackpay = (q.st == link_pkg::S_LISTEN) && data_rx && !is_dup && q.ackpay_out;

   retry_timer #(
      .UNIT_CYC(UNIT_CYC),
      .SLOT_W(4),
      .CNT_W(16)
   ) u_timer (
      .mclk(mclk),
      .rstn(rstn),
      .ce(ce),
      .run(q.st == link_pkg::S_WAIT),
      .slot(q.retry_cfg[link_pkg::RETRY_SLOT_LSB +: 4]),
      .timeout(timeout)
   );

   dup_filter #(
      .PID_W(2),
      .CHK_W(16)
   ) u_dup (
      .mclk(mclk),
      .rstn(rstn),
      .ce(ce),
      .check((q.st == link_pkg::S_LISTEN) && data_rx),
      .flush(!primary_receiver),
      .packet_ident(air_rx_pid),
      .chk(air_rx_crc),
      .is_dup(is_dup)
   );

   always_comb begin
      n = q;
      n.tx_go = 1'b0;
      n.rfce_d = rfce;
      if (rfce_rise) begin
         n.blocked = 1'b0;
      end
      // Register writes; flag clears come before hardware sets so a set wins
      if (sfr_wr) begin
         if (hit(sfr_addr, link_pkg::ADDR_SPI_CFG0)) begin
            n.spi_cfg0 = sfr_wdata[6:0];
         end
         if (hit(sfr_addr, link_pkg::ADDR_RADIO_CTRL)) begin
            n.rctl = sfr_wdata[2:0];
         end
         if (hit(sfr_addr, link_pkg::ADDR_AA_MASK)) begin
            n.aa_mask = sfr_wdata[5:0];
         end
         if (hit(sfr_addr, link_pkg::ADDR_RETRY_CFG)) begin
            n.retry_cfg = sfr_wdata;
         end
         if (hit(sfr_addr, link_pkg::ADDR_STATUS)) begin
            n.rx_ready = q.rx_ready && !sfr_wdata[link_pkg::STAT_RXR_BIT];
            n.tx_sent = q.tx_sent && !sfr_wdata[link_pkg::STAT_TXS_BIT];
            n.retry_limit_flag = q.retry_limit_flag && !sfr_wdata[link_pkg::STAT_MRT_BIT];
         end
         // A full queue refuses a new byte
         if (hit(sfr_addr, link_pkg::ADDR_TX_DATA) && !q.txq_full) begin
            n.txq_full = 1'b1;
            n.txq_data = sfr_wdata;
         end
         if (hit(sfr_addr, link_pkg::ADDR_COMMAND) && sfr_wdata[link_pkg::CMD_PURGE_BIT]) begin
            n.txq_full = 1'b0;
            n.ackpay_out = 1'b0;
         end
      end
      case (q.st)
         link_pkg::S_IDLE: begin
            if (primary_receiver && rfce) begin
               n.st = link_pkg::S_LISTEN;
            end else if (!primary_receiver && rfce && q.txq_full && !n.blocked) begin
               n.rcnt = 4'h0;
               n.st = link_pkg::S_TX;
               n.tx_go = 1'b1;
               n.tx_ack = 1'b0;
            end
         end
         link_pkg::S_TX: begin
            if (air_tx_done) begin
               if (auto_ack) begin
                  n.st = link_pkg::S_WAIT;
               end else begin
                  n.tx_sent = 1'b1;
                  n.txq_full = 1'b0;
                  n.packet_ident = q.packet_ident + 2'd1;
                  n.st = link_pkg::S_IDLE;
               end
            end
         end
         link_pkg::S_WAIT: begin
            if (ack_rx) begin
               n.tx_sent = 1'b1;
               if (air_rx_has_pay) begin
                  n.rx_ready = 1'b1;
                  n.rx_data = air_rx_data;
               end
               n.txq_full = 1'b0;
               n.packet_ident = q.packet_ident + 2'd1;
               n.st = link_pkg::S_IDLE;
            end else if (timeout) begin
               if (q.rcnt == limit) begin
                  n.retry_limit_flag = 1'b1;
                  n.blocked = 1'b1;
                  n.st = link_pkg::S_IDLE;
               end else begin
                  n.rcnt = q.rcnt + 4'h1;
                  n.st = link_pkg::S_TX;
                  n.tx_go = 1'b1;
                  n.tx_ack = 1'b0;
               end
            end
         end
         link_pkg::S_LISTEN: begin
            if (!rfce || !primary_receiver) begin
               n.st = link_pkg::S_IDLE;
            end else if (data_rx) begin
               if (!is_dup) begin
                  n.rx_ready = 1'b1;
                  n.rx_data = air_rx_data;
               end
               if (pop_ackpay) begin
                  n.tx_sent = 1'b1;
                  n.txq_full = 1'b0;
                  n.ackpay_out = 1'b0;
               end
               // A copy still gets an acknowledgement, its first one may be lost
               if (auto_ack) begin
                  n.st = link_pkg::S_ACK;
                  n.tx_go = 1'b1;
                  n.tx_ack = 1'b1;
                  n.tx_pid = air_rx_pid;
                  n.tx_data = n.txq_data;
                  n.tx_pay = n.txq_full;
               end
            end
         end
         link_pkg::S_ACK: begin
            if (air_tx_done) begin
               n.ackpay_out = q.ackpay_out || q.tx_pay;
               n.st = link_pkg::S_LISTEN;
            end
         end
         default: begin
            n.st = link_pkg::S_IDLE;
         end
      endcase
      // Data frames carry the queued byte and current identifier unchanged
      if (n.tx_go && !n.tx_ack) begin
         n.tx_pid = q.packet_ident;
         n.tx_data = q.txq_data;
         n.tx_pay = 1'b1;
      end
      if (n.tx_go) begin
         n.tx_pcf = !legacy;
         n.tx_crc = !legacy || q.rctl[link_pkg::RCTL_CRC_BIT];
      end
      // Read data registered; unmapped addresses read zero
      if (sfr_rd) begin
         if (hit(sfr_addr, link_pkg::ADDR_SPI_CFG0)) begin
            n.rdata = {1'b0, q.spi_cfg0};
         end else if (hit(sfr_addr, link_pkg::ADDR_RADIO_CTRL)) begin
            n.rdata = {5'h00, q.rctl};
         end else if (hit(sfr_addr, link_pkg::ADDR_AA_MASK)) begin
            n.rdata = {2'h0, q.aa_mask};
         end else if (hit(sfr_addr, link_pkg::ADDR_RETRY_CFG)) begin
            n.rdata = q.retry_cfg;
         end else if (hit(sfr_addr, link_pkg::ADDR_STATUS)) begin
            n.rdata = {q.rcnt, q.txq_full, q.retry_limit_flag, q.tx_sent, q.rx_ready};
         end else if (hit(sfr_addr, link_pkg::ADDR_RX_DATA)) begin
            n.rdata = q.rx_data;
         end else begin
            n.rdata = 8'h00;
         end
      end
      if (!rstn) begin
         n = '0;
         n.st = link_pkg::S_IDLE;
         n.spi_cfg0 = link_pkg::SPI_CFG0_RST;
         n.rctl = link_pkg::RADIO_CTRL_RST;
         n.aa_mask = link_pkg::AA_MASK_RST;
         n.retry_cfg = link_pkg::RETRY_CFG_RST;
      end
   end

   always_ff @(posedge mclk) begin
      if (ce || !rstn) begin
         q <= n;
      end
   end

   assign sfr_rdata = q.rdata;
   assign air_tx_valid = q.tx_go;
   assign air_tx_is_ack = q.tx_ack;
   assign air_tx_pid = q.tx_pid;
   assign air_tx_data = q.tx_data;
   assign air_tx_has_pay = q.tx_pay;
   assign air_tx_has_pcf = q.tx_pcf;
   assign air_tx_has_crc = q.tx_crc;
   assign radio_rx_on = (q.st == link_pkg::S_WAIT) || (q.st == link_pkg::S_LISTEN);
   assign spi_cfg0 = q.spi_cfg0;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   sequence s_sent_with_ack;
      ce && q.st == link_pkg::S_TX && air_tx_done && auto_ack;
   endsequence
   sequence s_slot_missed;
      ce && q.st == link_pkg::S_WAIT && !ack_rx && timeout;
   endsequence

   AST_ACK_LISTEN: assert property (s_sent_with_ack |=> radio_rx_on && q.st == link_pkg::S_WAIT)
      else $error("Transmitter did not listen for acknowledgement");
   AST_RESEND: assert property (s_slot_missed ##0 (q.rcnt != limit)
      |=> air_tx_valid && !air_tx_is_ack && air_tx_pid == $past(q.packet_ident))
      else $error("Missed acknowledgement did not resend the same packet");
   AST_RX_FIRST: assert property (ce && q.st == link_pkg::S_LISTEN && rfce && primary_receiver && data_rx && !is_dup
      |=> q.rx_ready && q.rx_data == $past(air_rx_data))
      else $error("Accepted packet not flagged");
   AST_DROP_COPY: assert property (ce && q.st == link_pkg::S_LISTEN && data_rx && is_dup
      |=> $stable(q.rx_data))
      else $error("Duplicate packet delivered");
   AST_ACK_BOTH: assert property (ce && q.st == link_pkg::S_WAIT && ack_rx && air_rx_has_pay
      |=> q.tx_sent && q.rx_ready && !q.txq_full)
      else $error("Acknowledgement payload flags not raised together");
   AST_ACKPAY_SENT: assert property (ce && rfce && primary_receiver && pop_ackpay |=> q.tx_sent && q.rx_ready)
      else $error("Ack payload sent flag not raised with next packet");
   AST_RETRY_LIMIT: assert property (s_slot_missed ##0 (q.rcnt == limit)
      |=> q.retry_limit_flag && q.st == link_pkg::S_IDLE && q.txq_full ##1 !air_tx_valid)
      else $error("Retry limit not handled");
   AST_HOLD_QUEUE: assert property (q.blocked && !rfce_rise |-> !(n.tx_go && !n.tx_ack))
      else $error("Transmission restarted without chip-enable toggle");
   AST_PURGE: assert property (ce && sfr_wr && sfr_addr == link_pkg::ADDR_COMMAND
      && sfr_wdata[link_pkg::CMD_PURGE_BIT] && q.st != link_pkg::S_LISTEN |=> !q.txq_full)
      else $error("Purge left payload queued");
   AST_LEGACY_FMT: assert property (air_tx_valid && $past(legacy) |-> !air_tx_has_pcf)
      else $error("Legacy frame carries control field");
endmodule
`default_nettype wire

// ==== auto_ack_retransmit_link_tb.sv ====
// Self-checking bench of the auto-ack link through its register port
`default_nettype none
module auto_ack_retransmit_link_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic air_tx_valid, air_tx_is_ack, air_tx_has_pay, air_tx_has_pcf, air_tx_has_crc, air_tx_done;
   logic [1:0] air_tx_pid, air_rx_pid;
   logic [7:0] air_tx_data, air_rx_data;
   logic radio_rx_on, air_rx_valid, air_rx_is_ack, air_rx_has_pay, air_rx_crc_ok;
   logic [15:0] air_rx_crc;
   logic [6:0] spi_cfg0;
   int num_errors = 0;
   int checked = 0;
   int tx_frames = 0;
   int cycles = 0;
   initial forever #50 mclk = ~mclk;
   // Short wait unit keeps the slot at 16 cycles for slot code 3
   auto_ack_retransmit_link #(.UNIT_CYC(4)) uut (.mclk(mclk), .rstn(rstn), .ce(ce), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .air_tx_valid(air_tx_valid), .air_tx_is_ack(air_tx_is_ack), .air_tx_pid(air_tx_pid),
      .air_tx_data(air_tx_data), .air_tx_has_pay(air_tx_has_pay), .air_tx_has_pcf(air_tx_has_pcf),
      .air_tx_has_crc(air_tx_has_crc), .air_tx_done(air_tx_done), .radio_rx_on(radio_rx_on),
      .air_rx_valid(air_rx_valid), .air_rx_is_ack(air_rx_is_ack), .air_rx_has_pay(air_rx_has_pay),
      .air_rx_crc_ok(air_rx_crc_ok), .air_rx_pid(air_rx_pid), .air_rx_crc(air_rx_crc),
      .air_rx_data(air_rx_data), .spi_cfg0(spi_cfg0));
   remote_radio peer (.mclk(mclk), .rstn(rstn), .air_tx_valid(air_tx_valid), .air_tx_is_ack(air_tx_is_ack),
      .air_tx_pid(air_tx_pid), .air_tx_done(air_tx_done), .air_rx_valid(air_rx_valid),
      .air_rx_is_ack(air_rx_is_ack), .air_rx_has_pay(air_rx_has_pay), .air_rx_crc_ok(air_rx_crc_ok),
      .air_rx_pid(air_rx_pid), .air_rx_crc(air_rx_crc), .air_rx_data(air_rx_data));
   task automatic report_and_stop();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
      @(negedge mclk);
      sfr_addr = addr;
      sfr_wdata = data;
      sfr_wr = 1'b1;
      @(negedge mclk);
      sfr_wr = 1'b0;
   endtask
   task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
      @(negedge mclk);
      sfr_addr = addr;
      sfr_rd = 1'b1;
      @(negedge mclk);
      sfr_rd = 1'b0;
      data = sfr_rdata;
   endtask
   task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic check_reg(input string name, input logic [7:0] addr, input logic [7:0] exp,
                            input logic [7:0] mask);
      logic [7:0] v;
      sfr_read(addr, v);
      check8(name, exp, v & mask);
   endtask
   // Polls status until every bit of the mask is set, bounded
   task automatic wait_status(input logic [7:0] m);
      logic [7:0] v;
      v = 8'h00;
      for (int i = 0; i < 300 && (v & m) !== m; i++) sfr_read(link_pkg::ADDR_STATUS, v);
      if ((v & m) !== m) begin
         num_errors++;
         $display("MISMATCH status wait expected %h seen %h", m, v & m);
      end
   endtask
   task automatic wait_frames(input int n);
      for (int i = 0; i < 400 && tx_frames < n; i++) @(negedge mclk);
      if (tx_frames < n) begin
         num_errors++;
         $display("MISMATCH frame wait expected %0d seen %0d", n, tx_frames);
      end
   endtask
   task automatic wait_listen();
      for (int i = 0; i < 400 && radio_rx_on !== 1'b1; i++) @(negedge mclk);
      if (radio_rx_on !== 1'b1) begin
         num_errors++;
         $display("MISMATCH listen wait expected 1 seen %b", radio_rx_on);
      end
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (air_tx_valid === 1'b1) tx_frames++;
      if (cycles == 30000) begin
         num_errors++;
         report_and_stop();
      end
   end
   initial begin
      int f;
      repeat (8) @(negedge mclk);
      rstn = 1'b1;
      check8("spi_cfg0 port", 8'h01, {1'b0, spi_cfg0});
      check_reg("spi cfg0", link_pkg::ADDR_SPI_CFG0, 8'h01, 8'hFF);
      check_reg("radio ctrl", link_pkg::ADDR_RADIO_CTRL, 8'h04, 8'hFF);
      check_reg("ack mask", link_pkg::ADDR_AA_MASK, 8'h3F, 8'hFF);
      check_reg("retry cfg", link_pkg::ADDR_RETRY_CFG, 8'h03, 8'hFF);
      check_reg("unmapped", 8'h80, 8'h00, 8'hFF);
      sfr_write(link_pkg::ADDR_SPI_CFG0, 8'hFF);
      check_reg("spi cfg0 rw", link_pkg::ADDR_SPI_CFG0, 8'h7F, 8'hFF);
      check8("spi_cfg0 port rw", 8'h7F, {1'b0, spi_cfg0});
      // Clock enable low must freeze the register file
      ce = 1'b0;
      sfr_write(link_pkg::ADDR_SPI_CFG0, 8'h00);
      ce = 1'b1;
      check_reg("spi cfg0 frozen", link_pkg::ADDR_SPI_CFG0, 8'h7F, 8'hFF);
      // Plain acknowledged packet, slot code 3 and limit 2
      sfr_write(link_pkg::ADDR_RETRY_CFG, 8'h32);
      f = tx_frames;
      sfr_write(link_pkg::ADDR_TX_DATA, 8'hA5);
      sfr_write(link_pkg::ADDR_RADIO_CTRL, 8'h05);
      wait_status(8'h02);
      check8("frames once", 8'(f + 1), 8'(tx_frames));
      check8("rx off after ack", 8'h00, {7'h00, radio_rx_on});
      check8("first pid", 8'h00, {6'h00, air_tx_pid});
      check8("tx data", 8'hA5, air_tx_data);
      check8("tx fields", 8'h07, {5'h00, air_tx_has_pay, air_tx_has_pcf, air_tx_has_crc});
      check_reg("status sent", link_pkg::ADDR_STATUS, 8'h02, 8'hFF);
      sfr_write(link_pkg::ADDR_STATUS, 8'h07);
      check_reg("status clear", link_pkg::ADDR_STATUS, 8'h00, 8'h07);
      // Lost ack with an ack payload; the gap lets the far side load its payload
      peer.drop_n = 1;
      peer.ack_pay = 1'b1;
      peer.ack_byte = 8'h3C;
      repeat (1300) @(negedge mclk);
      f = tx_frames;
      sfr_write(link_pkg::ADDR_TX_DATA, 8'h5A);
      wait_status(8'h02);
      check8("resent", 8'(f + 2), 8'(tx_frames));
      check8("resend pid", 8'h01, {6'h00, air_tx_pid});
      check_reg("status ack pay", link_pkg::ADDR_STATUS, 8'h13, 8'hFF);
      check_reg("ack payload", link_pkg::ADDR_RX_DATA, 8'h3C, 8'hFF);
      sfr_write(link_pkg::ADDR_STATUS, 8'h07);
      // No acks at all: limit reached, payload kept, restart by chip-enable toggle
      peer.drop_n = 100;
      f = tx_frames;
      sfr_write(link_pkg::ADDR_TX_DATA, 8'h77);
      wait_status(8'h04);
      check8("sends at limit", 8'(f + 3), 8'(tx_frames));
      check_reg("status limit", link_pkg::ADDR_STATUS, 8'h2C, 8'hFF);
      repeat (60) @(negedge mclk);
      check8("no restart", 8'(f + 3), 8'(tx_frames));
      sfr_write(link_pkg::ADDR_STATUS, 8'h07);
      sfr_write(link_pkg::ADDR_RADIO_CTRL, 8'h04);
      sfr_write(link_pkg::ADDR_RADIO_CTRL, 8'h05);
      wait_frames(f + 4);
      check8("restart pid", 8'h02, {6'h00, air_tx_pid});
      check8("restart data", 8'h77, air_tx_data);
      wait_status(8'h04);
      sfr_write(link_pkg::ADDR_COMMAND, 8'h01);
      check_reg("purged", link_pkg::ADDR_STATUS, 8'h00, 8'h08);
      sfr_write(link_pkg::ADDR_STATUS, 8'h07);
      // Legacy format; the air rate stays low, it is set outside this block
      sfr_write(link_pkg::ADDR_AA_MASK, 8'h00);
      sfr_write(link_pkg::ADDR_RETRY_CFG, 8'h30);
      // Chip enable must drop first, the retry-limit hold is still set
      sfr_write(link_pkg::ADDR_RADIO_CTRL, 8'h00);
      sfr_write(link_pkg::ADDR_RADIO_CTRL, 8'h01);
      f = tx_frames;
      sfr_write(link_pkg::ADDR_TX_DATA, 8'h11);
      wait_status(8'h02);
      check8("legacy fields", 8'h04, {5'h00, air_tx_has_pay, air_tx_has_pcf, air_tx_has_crc});
      check8("legacy once", 8'(f + 1), 8'(tx_frames));
      check8("legacy data", 8'h11, air_tx_data);
      sfr_write(link_pkg::ADDR_STATUS, 8'h07);
      sfr_write(link_pkg::ADDR_RADIO_CTRL, 8'h05);
      sfr_write(link_pkg::ADDR_TX_DATA, 8'h22);
      wait_status(8'h02);
      check8("legacy crc", 8'h05, {5'h00, air_tx_has_pay, air_tx_has_pcf, air_tx_has_crc});
      sfr_write(link_pkg::ADDR_STATUS, 8'h07);
      // Receiver with a queued ack payload, a duplicate, then a new packet
      sfr_write(link_pkg::ADDR_AA_MASK, 8'h3F);
      sfr_write(link_pkg::ADDR_RETRY_CFG, 8'h32);
      sfr_write(link_pkg::ADDR_RADIO_CTRL, 8'h04);
      sfr_write(link_pkg::ADDR_TX_DATA, 8'h99);
      sfr_write(link_pkg::ADDR_RADIO_CTRL, 8'h07);
      wait_listen();
      f = tx_frames;
      peer.send_frame(1'b0, 1'b0, 2'h1, 16'h1234, 8'hC1);
      wait_frames(f + 1);
      check8("ack frame", 8'h0D, {4'h0, air_tx_is_ack, air_tx_has_pay, air_tx_pid});
      check_reg("status first", link_pkg::ADDR_STATUS, 8'h09, 8'hFF);
      check_reg("rx data", link_pkg::ADDR_RX_DATA, 8'hC1, 8'hFF);
      sfr_write(link_pkg::ADDR_STATUS, 8'h07);
      wait_listen();
      peer.send_frame(1'b0, 1'b0, 2'h1, 16'h1234, 8'hC2);
      wait_frames(f + 2);
      check8("dup acked", 8'(f + 2), 8'(tx_frames));
      check_reg("dup no flag", link_pkg::ADDR_STATUS, 8'h00, 8'h01);
      check_reg("dup data kept", link_pkg::ADDR_RX_DATA, 8'hC1, 8'hFF);
      wait_listen();
      peer.send_frame(1'b0, 1'b0, 2'h2, 16'h5678, 8'hC3);
      wait_frames(f + 3);
      check_reg("status next", link_pkg::ADDR_STATUS, 8'h03, 8'h0F);
      check_reg("next data", link_pkg::ADDR_RX_DATA, 8'hC3, 8'hFF);
      report_and_stop();
   end
endmodule
`default_nettype wire

// ==== dup_filter.sv ====
// Remembers the last accepted packet identity to drop retransmitted copies
`default_nettype none
module dup_filter #(
   parameter int PID_W = 2,
   parameter int CHK_W = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   // Packet identity
   input wire logic check,
   input wire logic flush,
   input wire logic [PID_W-1:0] packet_ident,
   input wire logic [CHK_W-1:0] chk,
   output logic is_dup
);
   typedef struct packed {
      logic valid;
      logic [PID_W-1:0] packet_ident;
      logic [CHK_W-1:0] chk;
   } dup_state_type;
   dup_state_type q, n;

   if (PID_W < 1 || CHK_W < 1) begin : g_chk
      $error("dup_filter: widths must be positive");
   end

   // Same identifier and same checksum means a copy
   assign is_dup = q.valid && (q.packet_ident == packet_ident) && (q.chk == chk);

   always_comb begin
      n = q;
      if (flush) begin
         n.valid = 1'b0;
      end else if (check && !is_dup) begin
         n.valid = 1'b1;
         n.packet_ident = packet_ident;
         n.chk = chk;
      end
      if (!rstn) begin
         n = '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (ce || !rstn) begin
         q <= n;
      end
   end

   AST_DUP_STORE: assert property (@(posedge mclk) disable iff (!rstn)
      ce && check && !flush |=> is_dup || !(packet_ident == $past(packet_ident) && chk == $past(chk)))
      else $error("Accepted identity not remembered");
endmodule
`default_nettype wire

// ==== link_pkg.sv ====
// Shared constants, register map and state encoding of the auto-ack link
`default_nettype none
package link_pkg;
   // Special-function register addresses
   localparam logic [7:0] ADDR_SPI_CFG0 = 8'hE4;
   localparam logic [7:0] ADDR_RADIO_CTRL = 8'hD0;
   localparam logic [7:0] ADDR_AA_MASK = 8'hD1;
   localparam logic [7:0] ADDR_RETRY_CFG = 8'hD2;
   localparam logic [7:0] ADDR_STATUS = 8'hD3;
   localparam logic [7:0] ADDR_TX_DATA = 8'hD4;
   localparam logic [7:0] ADDR_RX_DATA = 8'hD5;
   localparam logic [7:0] ADDR_COMMAND = 8'hD6;
   // Field positions
   localparam int RCTL_CE_BIT = 0;
   localparam int RCTL_PRX_BIT = 1;
   localparam int RCTL_CRC_BIT = 2;
   localparam int STAT_RXR_BIT = 0;
   localparam int STAT_TXS_BIT = 1;
   localparam int STAT_MRT_BIT = 2;
   localparam int STAT_TXQ_BIT = 3;
   localparam int CMD_PURGE_BIT = 0;
   localparam int RETRY_LIM_LSB = 0;
   localparam int RETRY_SLOT_LSB = 4;
   // Reset values
   localparam logic [6:0] SPI_CFG0_RST = 7'h01;
   localparam logic [2:0] RADIO_CTRL_RST = 3'h4;
   localparam logic [5:0] AA_MASK_RST = 6'h3F;
   localparam logic [7:0] RETRY_CFG_RST = 8'h03;
   // Timing: one ack wait slot unit, least time, rounded up
   localparam int CLK_PERIOD_NS = 100;
   localparam int WAIT_UNIT_NS = 250000;
   localparam int WAIT_UNIT_CYC = (WAIT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_TX = 3'b001,
      S_WAIT = 3'b010,
      S_LISTEN = 3'b011,
      S_ACK = 3'b100
   } state_type;
endpackage
`default_nettype wire

// ==== remote_radio.sv ====
// Behavioural far-side radio: finishes frames, answers with acks, injects frames
`default_nettype none
module remote_radio (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // Frames from the link
   input wire logic air_tx_valid,
   input wire logic air_tx_is_ack,
   input wire logic [1:0] air_tx_pid,
   output logic air_tx_done,
   // Frames to the link
   output logic air_rx_valid,
   output logic air_rx_is_ack,
   output logic air_rx_has_pay,
   output logic air_rx_crc_ok,
   output logic [1:0] air_rx_pid,
   output logic [15:0] air_rx_crc,
   output logic [7:0] air_rx_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // Acks to swallow, air time in cycles and the ack payload, set by the bench
   int drop_n = 0;
   int tx_lat = 3;
   logic ack_pay = 1'b0;
   logic [7:0] ack_byte = 8'h00;
   initial begin
      air_tx_done = 1'b0;
      air_rx_valid = 1'b0;
      air_rx_is_ack = 1'b0;
      air_rx_has_pay = 1'b0;
      air_rx_crc_ok = 1'b0;
      air_rx_pid = 2'h0;
      air_rx_crc = 16'hFFFF;
      air_rx_data = 8'hFF;
   end
   task automatic send_frame(input logic is_ack, input logic has_pay, input logic [1:0] packet_ident,
                             input logic [15:0] crc, input logic [7:0] data);
      @(negedge mclk);
      air_rx_valid = 1'b1;
      air_rx_crc_ok = 1'b1;
      air_rx_is_ack = is_ack;
      air_rx_has_pay = has_pay;
      air_rx_pid = packet_ident;
      air_rx_crc = crc;
      air_rx_data = data;
      @(negedge mclk);
      // Released lines carry the inverse, so a stale frame can never look valid
      air_rx_valid = 1'b0;
      air_rx_crc_ok = 1'b0;
      air_rx_is_ack = ~is_ack;
      air_rx_has_pay = ~has_pay;
      air_rx_pid = ~packet_ident;
      air_rx_crc = ~crc;
      air_rx_data = ~data;
   endtask
   always begin
      @(posedge mclk);
      if (rstn && air_tx_valid === 1'b1) begin
         repeat (tx_lat) @(negedge mclk);
         air_tx_done = 1'b1;
         @(negedge mclk);
         air_tx_done = 1'b0;
         // Only data frames are answered; a lost ack is simply never sent
         if (air_tx_is_ack !== 1'b1) begin
            if (drop_n > 0) begin
               drop_n--;
            end else begin
               repeat (2) @(negedge mclk);
               send_frame(1'b1, ack_pay, air_tx_pid, 16'h0000, ack_byte);
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== retry_timer.sv ====
// Acknowledgement wait slot timer, restarted whenever run drops
`default_nettype none
module retry_timer #(
   parameter int UNIT_CYC = link_pkg::WAIT_UNIT_CYC,
   parameter int SLOT_W = 4,
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   // Control
   input wire logic run,
   input wire logic [SLOT_W-1:0] slot,
   output logic timeout
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
   } timer_state_type;
   timer_state_type q, n;
   logic [CNT_W-1:0] lim;

   if (((2 ** SLOT_W) * UNIT_CYC) >= (2 ** CNT_W) || UNIT_CYC < 1) begin : g_chk
      $error("retry_timer: counter too narrow for the wait slot");
   end

   // Slot code k waits k+1 units
   assign lim = CNT_W'((int'(slot) + 1) * UNIT_CYC - 1);
   assign timeout = run && (q.cnt == lim);

   always_comb begin
      n = q;
      if (!run || timeout) begin
         n.cnt = '0;
      end else begin
         n.cnt = q.cnt + CNT_W'(1);
      end
      if (!rstn) begin
         n.cnt = '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (ce || !rstn) begin
         q <= n;
      end
   end

   AST_TIMER_SPAN: assert property (@(posedge mclk) disable iff (!rstn)
      ce && run && !timeout |=> q.cnt == $past(q.cnt) + CNT_W'(1))
      else $error("Wait slot counter stalled");
endmodule
`default_nettype wire
